// [hw/rcs_pkg.sv]
package rcs_pkg;

  // Special-function address of the reset cause register
  localparam logic [7:0] RCS_REG_ADDR = 8'hEF;

  // One-hot cause and enable positions in the register
  localparam logic [7:0] RCS_C_RTC = 8'h80;
  localparam logic [7:0] RCS_C_FERR = 8'h40;
  localparam logic [7:0] RCS_C_CMP = 8'h20;
  localparam logic [7:0] RCS_C_SW = 8'h10;
  localparam logic [7:0] RCS_C_WDT = 8'h08;
  localparam logic [7:0] RCS_C_MCD = 8'h04;
  localparam logic [7:0] RCS_C_POR = 8'h02;
  localparam logic [7:0] RCS_C_PIN = 8'h01;

  // Bits that hold a stored source enable
  localparam logic [7:0] RCS_EN_MASK = 8'hA6;
  // Enables after any reset: supply monitor stays selected
  localparam logic [7:0] RCS_EN_RESET = 8'h02;
  // Cause register value after power-on
  localparam logic [7:0] RCS_CAUSE_POR = 8'h02;
  localparam logic [7:0] RCS_ZERO8 = 8'h00;

  // Watchdog clock divider: system clock divided by twelve
  localparam int unsigned RCS_WDT_DIV = 12;
  localparam logic [3:0] RCS_WDT_LAST = 4'(RCS_WDT_DIV - 1);
  localparam logic [3:0] RCS_CNT_ZERO = 4'h0;
  localparam logic [3:0] RCS_CNT_ONE = 4'h1;

  // Last hold count of the internal system reset pulse, which lasts eight cycles
  localparam logic [3:0] RCS_HOLD_LAST = 4'h7;

  // Synchroniser reset value: pin high, supply ok, comparator high, no mcd
  localparam logic [3:0] RCS_SYNC_RESET = 4'h7;

  typedef enum logic [1:0] {
    RCS_RUN = 2'b00,
    RCS_HOLD = 2'b01,
    RCS_PIN = 2'b10
  } rcs_state_t;

  // True when an access lands above the lock byte address
  function automatic logic rcs_above_lock(input logic [15:0] addr,
                                          input logic [15:0] lock);
    return addr > lock;
  endfunction

endpackage

// [hw/rcs_rtc_if.sv]
interface rcs_rtc_if;
  logic alarm_evt;
  logic osc_fail_evt;
  modport src (output alarm_evt, output osc_fail_evt);
  modport snk (input alarm_evt, input osc_fail_evt);
endinterface

// [hw/rcs_rtc_event.sv]
module rcs_rtc_event (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Real-time clock state
  input wire logic rtc_mcd_en_in,
  input wire logic rtc_clk_slow_in,
  input wire logic alarm_en_in,
  input wire logic [31:0] rtc_timer_in,
  input wire logic [31:0] alarm_compare_in,
  // Events toward the reset logic
  rcs_rtc_if.src evt
);
  import rcs_pkg::*;

  logic slow_s1_q;
  logic slow_s2_q;
  logic match_q;

  // Slow-clock detector level comes from another domain
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
    end else begin
      slow_s1_q <= rtc_clk_slow_in;
      slow_s2_q <= slow_s1_q;
    end
  end

  // Oscillator fail only while its detector is enabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      evt.osc_fail_evt <= 1'b0;
    end else begin
      evt.osc_fail_evt <= rtc_mcd_en_in & slow_s2_q;
    end
  end

  // Alarm fires on timer equal to compare value
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      match_q <= 1'b0;
      evt.alarm_evt <= 1'b0;
    end else begin
      match_q <= alarm_en_in && (rtc_timer_in == alarm_compare_in);
      evt.alarm_evt <= match_q;
    end
  end

endmodule

// [hw/rcs_reset_source_control.sv]
module rcs_reset_source_control (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Special-function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_rmw_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // Asynchronous reset sources
  input wire logic rst_pin_in,
  input wire logic vdd_ok_in,
  input wire logic comparator_in,
  input wire logic missing_clock_in,
  // Watchdog function of the counter array
  input wire logic wdt_expire_in,
  input wire logic wdt_disable_in,
  output logic wdt_enable_out,
  output logic wdt_tick_out,
  // Flash access monitor
  input wire logic [15:0] flash_addr_in,
  input wire logic [15:0] lock_byte_addr_in,
  input wire logic program_store_write_enable_in,
  input wire logic xdata_write_in,
  input wire logic code_read_in,
  input wire logic fetch_in,
  input wire logic security_block_in,
  input wire logic flash_modify_in,
  input wire logic vdd_mon_enabled_in,
  // Real-time clock
  input wire logic rtc_mcd_en_in,
  input wire logic rtc_clk_slow_in,
  input wire logic alarm_en_in,
  input wire logic [31:0] rtc_timer_in,
  input wire logic [31:0] alarm_compare_in,
  // Reset outputs and reset pin
  output logic sys_reset_out,
  output logic missing_clock_en_out,
  output logic rst_pin_out,
  output logic rst_pin_oe_out
);
  import rcs_pkg::*;

  rcs_rtc_if rtc_evt ();
  rcs_state_t state_q;
  logic [3:0] sync_s1_q, sync_s2_q;
  logic [7:0] cause_q, en_q, req_d, pick_d, rdata_q;
  logic [3:0] hold_q, div_q;
  logic sys_reset_q, wdt_en_q, wdt_tick_q, oe_q, pin_q;
  logic reg_hit, ferr_d, pin_n_s, vdd_ok_s, cmp_s, mcd_s;

  rcs_rtc_event u_rtc (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .rtc_mcd_en_in(rtc_mcd_en_in),
    .rtc_clk_slow_in(rtc_clk_slow_in),
    .alarm_en_in(alarm_en_in),
    .rtc_timer_in(rtc_timer_in),
    .alarm_compare_in(alarm_compare_in),
    .evt(rtc_evt)
  );

  // Lowest bit wins when several sources fire together
  function automatic logic [7:0] pick_cause(input logic [7:0] req);
    logic [7:0] one;
    one = RCS_ZERO8;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        one = RCS_C_PIN << i;
      end
    end
    return one;
  endfunction
  // Two-flop synchronisers for pin and analog levels
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_s1_q <= RCS_SYNC_RESET;
      sync_s2_q <= RCS_SYNC_RESET;
    end else begin
      sync_s1_q <= {missing_clock_in, comparator_in, vdd_ok_in, rst_pin_in};
      sync_s2_q <= sync_s1_q;
    end
  end

  assign pin_n_s = sync_s2_q[0];
  assign vdd_ok_s = sync_s2_q[1];
  assign cmp_s = sync_s2_q[2];
  assign mcd_s = sync_s2_q[3];
  assign reg_hit = (sfr_addr_in == RCS_REG_ADDR);
  // Illegal flash accesses
  always_comb begin
    ferr_d = 1'b0;
    if (program_store_write_enable_in && xdata_write_in &&
        rcs_above_lock(flash_addr_in, lock_byte_addr_in)) begin
      ferr_d = 1'b1;
    end
    if (code_read_in && rcs_above_lock(flash_addr_in, lock_byte_addr_in)) begin
      ferr_d = 1'b1;
    end
    if (fetch_in && rcs_above_lock(flash_addr_in, lock_byte_addr_in)) begin
      ferr_d = 1'b1;
    end
    if (security_block_in) begin
      ferr_d = 1'b1;
    end
    if (flash_modify_in && !vdd_mon_enabled_in) begin
      ferr_d = 1'b1;
    end
  end

  // Gathered reset requests; pin, software and flash error requests have no enable gate
  always_comb begin
    req_d = RCS_ZERO8;
    if (|(en_q & RCS_C_RTC) &&
        (rtc_evt.alarm_evt || rtc_evt.osc_fail_evt)) begin
      req_d = req_d | RCS_C_RTC;
    end
    if (ferr_d) begin
      req_d = req_d | RCS_C_FERR;
    end
    if (|(en_q & RCS_C_CMP) && !cmp_s) begin
      req_d = req_d | RCS_C_CMP;
    end
    if (sfr_wr_in && reg_hit && |(sfr_wdata_in & RCS_C_SW)) begin
      req_d = req_d | RCS_C_SW;
    end
    if (wdt_en_q && wdt_expire_in) begin
      req_d = req_d | RCS_C_WDT;
    end
    if (|(en_q & RCS_C_MCD) && mcd_s) begin
      req_d = req_d | RCS_C_MCD;
    end
    if (|(en_q & RCS_C_POR) && !vdd_ok_s) begin
      req_d = req_d | RCS_C_POR;
    end
    if (!pin_n_s) begin
      req_d = req_d | RCS_C_PIN;
    end
    pick_d = pick_cause(req_d);
  end

  // Reset sequencer and cause capture
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_q <= RCS_HOLD;
      cause_q <= RCS_CAUSE_POR;
      hold_q <= RCS_CNT_ZERO;
      sys_reset_q <= 1'b1;
    end else begin
      case (state_q)
        RCS_RUN: begin
          if (|req_d) begin
            sys_reset_q <= 1'b1;
            hold_q <= RCS_CNT_ZERO;
            if (|(req_d & RCS_C_PIN)) begin
              state_q <= RCS_PIN;
            end else begin
              cause_q <= pick_d;
              state_q <= RCS_HOLD;
            end
          end
        end
        RCS_PIN: begin
          if (pin_n_s) begin
            cause_q <= RCS_C_PIN;
            state_q <= RCS_HOLD;
          end
        end
        RCS_HOLD: begin
          hold_q <= hold_q + RCS_CNT_ONE;
          if (hold_q == RCS_HOLD_LAST) begin
            sys_reset_q <= 1'b0;
            state_q <= RCS_RUN;
          end
        end
        default: begin
          state_q <= RCS_RUN;
          sys_reset_q <= 1'b0;
        end
      endcase
    end
  end

  // Stored source enables, set back to RCS_EN_RESET by each reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      en_q <= RCS_EN_RESET;
    end else if (sys_reset_q) begin
      en_q <= RCS_EN_RESET;
    end else if (sfr_wr_in && reg_hit) begin
      en_q <= sfr_wdata_in & RCS_EN_MASK;
    end
  end
  // Register read: causes, or stored enables for read-modify-write
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_q <= RCS_ZERO8;
    end else if (sfr_rd_in && reg_hit) begin
      rdata_q <= sfr_rmw_in ? en_q : cause_q;
    end else begin
      rdata_q <= RCS_ZERO8;
    end
  end
  // Watchdog back on after any reset, divided tick
  always_ff @(posedge core_clk_in) begin
    if (rst_in || sys_reset_q) begin
      wdt_en_q <= 1'b1;
      div_q <= RCS_CNT_ZERO;
      wdt_tick_q <= 1'b0;
    end else begin
      if (wdt_disable_in) begin
        wdt_en_q <= 1'b0;
      end
      wdt_tick_q <= (div_q == RCS_WDT_LAST);
      div_q <= (div_q == RCS_WDT_LAST) ? RCS_CNT_ZERO
                                       : div_q + RCS_CNT_ONE;
    end
  end
  // Pin pulled low only by power-on, never internal causes
  always_ff @(posedge core_clk_in) begin
    oe_q <= rst_in;
    pin_q <= 1'b0;
  end

  assign sfr_rdata_out = rdata_q;
  assign sys_reset_out = sys_reset_q;
  assign wdt_enable_out = wdt_en_q;
  assign wdt_tick_out = wdt_tick_q;
  assign missing_clock_en_out = |(en_q & RCS_C_MCD);
  assign rst_pin_out = pin_q;
  assign rst_pin_oe_out = oe_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_wdt_after_reset: assert property ($fell(sys_reset_q) |-> wdt_en_q)
    else $error("watchdog not enabled after reset");
  a_wdt_tick_gap: assert property (wdt_tick_q |=> !wdt_tick_q [*8])
    else $error("watchdog tick too frequent");
  a_wdt_cause_set: assert property (state_q == RCS_RUN &&
    req_d == RCS_C_WDT |=> sys_reset_q && cause_q == RCS_C_WDT)
    else $error("watchdog reset not flagged");
  a_flash_error_rst: assert property (state_q == RCS_RUN && ferr_d
    |=> sys_reset_q && state_q == RCS_HOLD)
    else $error("flash error did not reset");
  a_ferr_flag_only: assert property (state_q == RCS_RUN &&
    req_d == RCS_C_FERR |=> cause_q == RCS_C_FERR)
    else $error("flash error flag wrong");
  a_pin_untouched: assert property (!$past(rst_in) |-> !oe_q)
    else $error("internal reset drove pin");
  a_rtc_gate_off: assert property (state_q == RCS_RUN &&
    !(|(en_q & RCS_C_RTC)) && (req_d & ~RCS_C_RTC) == RCS_ZERO8
    |=> !sys_reset_q)
    else $error("rtc event reset while disabled");
  a_sw_force_rst: assert property (state_q == RCS_RUN &&
    req_d == RCS_C_SW |=> sys_reset_q ##8 !sys_reset_q)
    else $error("software reset length wrong");
  a_rmw_enable_rd: assert property (sfr_rd_in && reg_hit &&
    sfr_rmw_in |=> rdata_q == $past(en_q))
    else $error("rmw read did not return enables");
  a_pin_flag_exit: assert property (state_q == RCS_PIN &&
    pin_n_s |=> cause_q == RCS_C_PIN ##1 sys_reset_q)
    else $error("pin flag not set on exit");
  a_cause_onehot: assert property ($onehot(cause_q))
    else $error("cause flags not one-hot");

  c_pin_reset: cover property (state_q == RCS_PIN ##1 state_q == RCS_HOLD);
  c_sw_reset: cover property (req_d == RCS_C_SW && state_q == RCS_RUN);
  c_wdt_reset: cover property (cause_q == RCS_C_WDT && !sys_reset_q);
  c_rtc_reset: cover property (cause_q == RCS_C_RTC && !sys_reset_q);

endmodule

// [bench/rcs_peer_model.sv]
module rcs_peer_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Watchdog tick and software neglect
  input wire logic wdt_tick_in,
  input wire logic starve_in,
  // Peripheral outputs
  output logic wdt_expire_out,
  output logic [31:0] rtc_timer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ticks_q;
  // Real-time timer advances every cycle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rtc_timer_out <= 32'h0000_0000;
    end else begin
      rtc_timer_out <= rtc_timer_out + 32'h0000_0001;
    end
  end
  // Counter array expires four ticks after software stops updating it
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !starve_in) begin
      ticks_q <= 4'h0;
    end else if (wdt_tick_in) begin
      ticks_q <= ticks_q + 4'h1;
    end
  end
  assign wdt_expire_out = starve_in && (ticks_q == 4'h4);
endmodule

// [bench/rcs_reset_source_control_tb.sv]
module rcs_reset_source_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcs_pkg::*;
  logic clk, rst, wr, rd, rmw, pin, vdd, cmp, missing_clock_detector, wdis, wexp, program_store_write_enable, xw;
  logic cr, fe, sec, fm, vmon, rmcd, rslow, aen, starve;
  logic wen, tick, srst, mcd_en, pin_o, pin_oe;
  logic [7:0] addr, wdata, rdata, d;
  logic [15:0] faddr, lock;
  logic [31:0] timer, acmp;
  int num_errors, samples_checked, cycles, n;

  rcs_reset_source_control rcs_reset_source_control_i (
    .core_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_rmw_in(rmw), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .rst_pin_in(pin), .vdd_ok_in(vdd),
    .comparator_in(cmp), .missing_clock_in(missing_clock_detector), .wdt_expire_in(wexp),
    .wdt_disable_in(wdis), .wdt_enable_out(wen), .wdt_tick_out(tick),
    .flash_addr_in(faddr), .lock_byte_addr_in(lock),
    .program_store_write_enable_in(program_store_write_enable), .xdata_write_in(xw),
    .code_read_in(cr), .fetch_in(fe), .security_block_in(sec),
    .flash_modify_in(fm), .vdd_mon_enabled_in(vmon),
    .rtc_mcd_en_in(rmcd), .rtc_clk_slow_in(rslow), .alarm_en_in(aen),
    .rtc_timer_in(timer), .alarm_compare_in(acmp), .sys_reset_out(srst),
    .missing_clock_en_out(mcd_en), .rst_pin_out(pin_o),
    .rst_pin_oe_out(pin_oe));

  rcs_peer_model rcs_peer_model_i (
    .core_clk_in(clk), .rst_in(rst), .wdt_tick_in(tick),
    .starve_in(starve), .wdt_expire_out(wexp), .rtc_timer_out(timer));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr8(input logic [7:0] v);
    @(posedge clk);
    addr <= RCS_REG_ADDR;
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd8(input logic m, output logic [7:0] v);
    @(posedge clk);
    addr <= RCS_REG_ADDR;
    rd <= 1'b1;
    rmw <= m;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Bounded wait for the system reset to reach a level
  task automatic wait_for(input logic lvl);
    n = 0;
    while (srst !== lvl && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h00, srst}, {7'h00, lvl});
  endtask

  // Raise or drop the request of one reset source
  task automatic drive(input int k, input logic on);
    @(posedge clk);
    case (k)
      0: if (on) wr8(8'h12);
      1: starve <= on;
      2: begin
        program_store_write_enable <= on;
        xw <= on;
      end
      3: cr <= on;
      4: fe <= on;
      5: sec <= on;
      6: begin
        fm <= on;
        vmon <= !on;
      end
      7: aen <= on;
      8: begin
        rmcd <= on;
        rslow <= on;
      end
      9: cmp <= !on;
      10: missing_clock_detector <= on;
      11: vdd <= !on;
      default: pin <= !on;
    endcase
  endtask

  function automatic logic [7:0] cause_of(input int k);
    case (k)
      0: return RCS_C_SW;
      1: return RCS_C_WDT;
      7, 8: return RCS_C_RTC;
      9: return RCS_C_CMP;
      10: return RCS_C_MCD;
      11: return RCS_C_POR;
      12: return RCS_C_PIN;
      default: return RCS_C_FERR;
    endcase
  endfunction

  function automatic logic [7:0] enable_of(input int k);
    case (k)
      7, 8: return 8'h82;
      9: return 8'h22;
      10: return 8'h06;
      default: return 8'h02;
    endcase
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {wr, rd, rmw, missing_clock_detector, wdis, program_store_write_enable, xw, cr, fe, sec, fm} = 11'h000;
    {rmcd, rslow, aen, starve} = 4'h0;
    {pin, vdd, cmp, vmon, rst} = 5'h1F;
    {addr, wdata, faddr, acmp} = 64'h0;
    void'($urandom(37454));
    // Lock byte placed at random so the bound is not a fixed value
    lock = 16'h4000 + 16'($urandom % 16384);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_for(1'b0);
    rd8(1'b0, d);
    check(d, RCS_CAUSE_POR);
    rd8(1'b1, d);
    check(d, RCS_EN_RESET);
    n = 0;
    while (tick !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 40);
    check(8'(n), 8'(RCS_WDT_DIV));
    $display("test power_on done");
    for (int k = 0; k < 13; k++) begin
      wr8(enable_of(k));
      rd8(1'b1, d);
      check(d, enable_of(k) & RCS_EN_MASK);
      check({7'h00, mcd_en}, {7'h00, k == 10});
      if (k != 1) begin
        @(posedge clk);
        wdis <= 1'b1;
        @(posedge clk);
        wdis <= 1'b0;
      end
      acmp <= timer + 32'd20 + ($urandom % 16);
      faddr <= lock + 16'h0001 + 16'($urandom % 64);
      drive(k, 1'b1);
      wait_for(1'b1);
      check({7'h00, pin_oe}, 8'h00);
      drive(k, 1'b0);
      wait_for(1'b0);
      check({6'h00, wen, pin_o}, 8'h02);
      rd8(1'b0, d);
      check(d, cause_of(k));
      $display("test source %0d done", k);
    end
    wr8(8'h02);
    faddr <= lock;
    fe <= 1'b1;
    rmcd <= 1'b1;
    rslow <= 1'b1;
    repeat (20) @(posedge clk);
    #1 check({7'h00, srst}, 8'h00);
    $display("test no_reset done");
    conclude();
  end
endmodule
